// file: sys_clock_ctrl.v
// Purpose: Timing generator and operating-mode controller of the system clock
// Assumes: hf_tick and lf_tick are one-cycle pulses, synchronous to clk_sys
// Notes:   Oscillators are modelled by their run enables and tick inputs
//
// Summary of operation
// - Timing generator: two-stage prescaler, 21-stage divider, clock and cycle counters.
// - Generator supplies divider output, timer, watchdog, timer/counter and warm-up clocks.
// - Prescaler and divider clear on reset, STOP entry and STOP release.
// - Seventh stage input chosen by mode, clock select and stage-7 source bit.
// - Slow and sleep modes always feed low clock into stage seven.
// - Warm-up after STOP from full speed feeds stage six into stage seven.
// - Machine cycle is four states S0 to S3, each one main clock.
// - Instructions last one to ten machine cycles; peripherals follow main clock.
// - Mode controller starts/stops oscillators, switches main clock via two registers.
// - Single clock: only high oscillator, low pins are ports, cycle four high clocks.
// - Reset enters full-speed single mode running everything from high clock.
// - Idle bit set enters idle: CPU and watchdog halt, peripherals run.
// - Any interrupt request releases idle back to full speed.
// - On idle release, accept interrupt if master enable set, else resume next.
// - Halt bit enters deep idle: only oscillator and base timer keep clock.
// - Falling edge of chosen base timer source ends deep idle, resumes full speed.
// - Deep idle ignores timer enable; service needs all three enables set.
// - Deep idle entered with timer enabled sets timer interrupt latch on return.
// - Dual clock runs both oscillators; main clock high in full/idle, low in slow/sleep.
// - Dual clock cycle is four high clocks, or four low clocks when slow.
// - Clock select one gives slow mode; zero returns full; high enable off stops high.
// - After warm-up, resume after STOP to full speed or slow per return select.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sys_clock_ctrl_consts.vh"

module sys_clock_ctrl #(
   parameter PRESCALE_W = `PRESCALE_BITS,
   parameter DIVIDER_W = `DIVIDER_BITS
) (
   input wire clk_sys,
   input wire arst_n,
   input wire ce,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_r,
   input wire hf_tick,
   input wire lf_tick,
   input wire irq_req,
   input wire irq_master_enable,
   input wire base_timer_irq_enable,
   input wire base_timer_irq_clear,
   input wire stop_release_n,
   input wire [3:0] inst_cycles,
   output reg [DIVIDER_W-1:0] div_taps_r,
   output reg main_tick_r,
   output reg [1:0] state_num_r,
   output reg cycle_end_r,
   output reg inst_done_r,
   output reg cpu_run_r,
   output reg wdt_run_r,
   output reg periph_run_r,
   output reg high_osc_run_r,
   output reg low_osc_run_r,
   output reg low_pins_port_r,
   output reg divider_output_r,
   output reg irq_accept_r,
   output reg resume_next_r,
   output reg base_timer_service_r,
   output reg base_timer_interrupt_r
);

   // ----------------------------------------------------------------
   // Modes
   // ----------------------------------------------------------------
   localparam [2:0] ST_RUN = 3'd0;
   localparam [2:0] ST_IDLE = 3'd1;
   localparam [2:0] ST_DEEP = 3'd2;
   localparam [2:0] ST_STOP = 3'd3;
   localparam [2:0] ST_WARM = 3'd4;

   reg [2:0] mode_r;
   reg [2:0] mode_nxt;
   reg [7:0] tgc_r;
   reg [7:0] sc1_r;
   reg [7:0] sc2_r;
   reg [PRESCALE_W-1:0] pre_r;
   reg stop_from_full_r;
   reg deep_tbt_en_r;
   reg tbt_tap_prev_r;
   reg stop_pin_prev_r;
   reg [3:0] mcycle_cnt_r;

   // ----------------------------------------------------------------
   // Clock selection
   // ----------------------------------------------------------------
   wire slow = sc2_r[`SC2_SYS_CLK_SEL];
   wire dual = sc2_r[`SC2_LOW_OSC_EN];
   wire hf_on = sc2_r[`SC2_HIGH_OSC_EN] && (mode_r != ST_STOP);
   wire lf_on = dual && (mode_r != ST_STOP);
   wire hf_run = hf_tick && hf_on;
   wire lf_run = lf_tick && lf_on;
   // Main clock: high in full and idle, low in slow and sleep
   wire main_tick = slow ? lf_run : hf_run;
   wire pre_carry = hf_run && (&pre_r);
   wire lo_carry = pre_carry && (&div_taps_r[5:0]);
   reg s7_tick;

   always @* begin
      s7_tick = 1'b0;
      if (slow) begin
         s7_tick = lf_run;
      end else if (mode_r == ST_WARM && stop_from_full_r) begin
         s7_tick = lo_carry;
      end else if (tgc_r[`TGC_DV7_SRC]) begin
         s7_tick = lf_run;
      end else begin
         s7_tick = lo_carry;
      end
   end

   // ----------------------------------------------------------------
   // Divider taps for the timer, warm-up and divider output
   // ----------------------------------------------------------------
   wire [4:0] tbt_idx = `TBT_TAP_BASE + {2'b00, tgc_r[`TGC_TBT_SEL_HI:`TGC_TBT_SEL_LO]};
   wire [4:0] warm_idx = `WARM_TAP_BASE + {3'b000, sc1_r[`SC1_WARM_HI:`SC1_WARM_LO]};
   wire [4:0] dvo_idx = `DIVOUT_TAP_BASE +
      {3'b000, tgc_r[`TGC_DIVOUT_SEL_HI:`TGC_DIVOUT_SEL_LO]};
   wire tbt_tap = div_taps_r[tbt_idx];
   wire tbt_fall = tbt_tap_prev_r && !tbt_tap;
   wire warm_done = div_taps_r[warm_idx];

   // Release pin is active low; edge mode waits for the falling edge
   wire stop_release = sc1_r[`SC1_REL_LEVEL] ? !stop_release_n :
      (stop_pin_prev_r && !stop_release_n);

   wire wr_tgc = reg_wr && (reg_addr == `OFS_TIMING_GEN_CONTROL);
   wire wr_sc1 = reg_wr && (reg_addr == `OFS_SYSTEM_CONTROL_ONE);
   wire wr_sc2 = reg_wr && (reg_addr == `OFS_SYSTEM_CONTROL_TWO);

   // ----------------------------------------------------------------
   // Mode sequencing
   // ----------------------------------------------------------------
   always @* begin
      mode_nxt = mode_r;
      case (mode_r)
         ST_RUN: begin
            if (sc1_r[`SC1_STOP]) begin
               mode_nxt = ST_STOP;
            end else if (sc2_r[`SC2_TG_HALT]) begin
               mode_nxt = ST_DEEP;
            end else if (sc2_r[`SC2_IDLE]) begin
               mode_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (irq_req) begin
               mode_nxt = ST_RUN;
            end
         end
         ST_DEEP: begin
            if (tbt_fall) begin
               mode_nxt = ST_RUN;
            end
         end
         ST_STOP: begin
            if (stop_release) begin
               mode_nxt = ST_WARM;
            end
         end
         ST_WARM: begin
            if (warm_done) begin
               mode_nxt = ST_RUN;
            end
         end
         default: begin
            mode_nxt = ST_RUN;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers, mode and timing generator
   // ----------------------------------------------------------------
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mode_r <= ST_RUN;
         tgc_r <= `RST_TIMING_GEN_CONTROL;
         sc1_r <= `RST_SYSTEM_CONTROL_ONE;
         sc2_r <= `RST_SYSTEM_CONTROL_TWO;
         pre_r <= {PRESCALE_W{1'b0}};
         div_taps_r <= {DIVIDER_W{1'b0}};
         stop_from_full_r <= 1'b0;
         deep_tbt_en_r <= 1'b0;
         tbt_tap_prev_r <= 1'b0;
         stop_pin_prev_r <= 1'b1;
         base_timer_interrupt_r <= 1'b0;
         irq_accept_r <= 1'b0;
         resume_next_r <= 1'b0;
         base_timer_service_r <= 1'b0;
      end else if (ce) begin
         mode_r <= mode_nxt;
         tbt_tap_prev_r <= tbt_tap;
         stop_pin_prev_r <= stop_release_n;
         irq_accept_r <= 1'b0;
         resume_next_r <= 1'b0;
         base_timer_service_r <= 1'b0;

         if (wr_tgc) begin
            tgc_r <= reg_wdata;
         end
         if (wr_sc1) begin
            sc1_r <= reg_wdata;
         end
         if (wr_sc2) begin
            sc2_r <= reg_wdata;
         end

         // Prescaler and divider; stages 1-6 stop with the high oscillator
         if ((mode_r == ST_RUN && sc1_r[`SC1_STOP]) ||
             (mode_r == ST_STOP && stop_release)) begin
            pre_r <= {PRESCALE_W{1'b0}};
            div_taps_r <= {DIVIDER_W{1'b0}};
         end else begin
            if (hf_run) begin
               pre_r <= pre_r + {{(PRESCALE_W-1){1'b0}}, 1'b1};
            end
            if (pre_carry) begin
               div_taps_r[5:0] <= div_taps_r[5:0] + 6'h01;
            end
            if (s7_tick) begin
               div_taps_r[DIVIDER_W-1:6] <= div_taps_r[DIVIDER_W-1:6] +
                  {{(DIVIDER_W-7){1'b0}}, 1'b1};
            end
         end

         case (mode_r)
            ST_RUN: begin
               if (sc1_r[`SC1_STOP]) begin
                  stop_from_full_r <= !slow;
               end else if (sc2_r[`SC2_TG_HALT]) begin
                  deep_tbt_en_r <= tgc_r[`TGC_TBT_EN];
               end
            end
            ST_IDLE: begin
               if (irq_req) begin
                  sc2_r[`SC2_IDLE] <= 1'b0;
                  irq_accept_r <= irq_master_enable;
                  resume_next_r <= !irq_master_enable;
               end
            end
            ST_DEEP: begin
               if (tbt_fall) begin
                  sc2_r[`SC2_TG_HALT] <= 1'b0;
                  base_timer_service_r <= irq_master_enable &&
                     base_timer_irq_enable && tgc_r[`TGC_TBT_EN];
               end
            end
            ST_WARM: begin
               if (warm_done) begin
                  sc1_r[`SC1_STOP] <= 1'b0;
                  if (sc1_r[`SC1_RET_SLOW]) begin
                     sc2_r[`SC2_SYS_CLK_SEL] <= 1'b1;
                     sc2_r[`SC2_HIGH_OSC_EN] <= 1'b0;
                  end else begin
                     sc2_r[`SC2_SYS_CLK_SEL] <= 1'b0;
                  end
               end
            end
            default: begin
            end
         endcase

         // Latch set on return wins over a clear in the same cycle
         if (mode_r == ST_DEEP && tbt_fall && deep_tbt_en_r) begin
            base_timer_interrupt_r <= 1'b1;
         end else if (base_timer_irq_clear) begin
            base_timer_interrupt_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Machine cycle and instruction timing
   // ----------------------------------------------------------------
   // Instruction lengths outside one to ten are clamped to keep the CPU live
   wire [3:0] inst_len = (inst_cycles == 4'h0) ? 4'h1 :
      ((inst_cycles > 4'ha) ? 4'ha : inst_cycles);

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         main_tick_r <= 1'b0;
         state_num_r <= 2'h0;
         cycle_end_r <= 1'b0;
         inst_done_r <= 1'b0;
         mcycle_cnt_r <= 4'h0;
      end else if (ce) begin
         main_tick_r <= main_tick && periph_run_r;
         cycle_end_r <= 1'b0;
         inst_done_r <= 1'b0;
         if (main_tick && periph_run_r) begin
            state_num_r <= state_num_r + 2'h1;
            if (state_num_r == 2'h3) begin
               cycle_end_r <= 1'b1;
               if (cpu_run_r) begin
                  if (mcycle_cnt_r + 4'h1 >= inst_len) begin
                     mcycle_cnt_r <= 4'h0;
                     inst_done_r <= 1'b1;
                  end else begin
                     mcycle_cnt_r <= mcycle_cnt_r + 4'h1;
                  end
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Run enables, oscillators, divider output and read port
   // ----------------------------------------------------------------
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cpu_run_r <= 1'b1;
         wdt_run_r <= 1'b1;
         periph_run_r <= 1'b1;
         high_osc_run_r <= 1'b1;
         low_osc_run_r <= 1'b0;
         low_pins_port_r <= 1'b1;
         divider_output_r <= 1'b0;
         reg_rdata_r <= 8'h00;
      end else if (ce) begin
         cpu_run_r <= (mode_nxt == ST_RUN);
         wdt_run_r <= (mode_nxt == ST_RUN);
         periph_run_r <= (mode_nxt == ST_RUN) || (mode_nxt == ST_IDLE);
         high_osc_run_r <= hf_on;
         low_osc_run_r <= lf_on;
         low_pins_port_r <= !dual;
         divider_output_r <= tgc_r[`TGC_DIVOUT_EN] && div_taps_r[dvo_idx];
         reg_rdata_r <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `OFS_TIMING_GEN_CONTROL: reg_rdata_r <= tgc_r;
               `OFS_SYSTEM_CONTROL_ONE: reg_rdata_r <= sc1_r;
               `OFS_SYSTEM_CONTROL_TWO: reg_rdata_r <= sc2_r;
               `OFS_MODE_STATUS: reg_rdata_r <= {3'b000, base_timer_interrupt_r,
                  state_num_r, 2'b00} | {5'b00000, mode_r};
               default: reg_rdata_r <= 8'h00;
            endcase
         end
      end
   end

endmodule // sys_clock_ctrl
`default_nettype wire

// file: sys_clock_ctrl_checker.sv
// Purpose: Port-level timing checks of the system clock controller
// Assumes: ce held high by the bench, one clock domain
// Notes:   Bound to every instance of sys_clock_ctrl
`timescale 1ns/1ps
`default_nettype none
module sys_clock_ctrl_checker (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata_r,
   input wire logic irq_req,
   input wire logic irq_master_enable,
   input wire logic base_timer_irq_enable,
   input wire logic base_timer_irq_clear,
   input wire logic [1:0] state_num_r,
   input wire logic cycle_end_r,
   input wire logic cpu_run_r,
   input wire logic wdt_run_r,
   input wire logic periph_run_r,
   input wire logic low_osc_run_r,
   input wire logic low_pins_port_r,
   input wire logic irq_accept_r,
   input wire logic resume_next_r,
   input wire logic base_timer_service_r,
   input wire logic base_timer_interrupt_r
);
// ----------------------------------------------------------------
// Properties
// ----------------------------------------------------------------
default clocking cb @(posedge clk_sys); endclocking
default disable iff (!arst_n);
chk_rdata_only_after: assert property (!$past(reg_rd) |-> reg_rdata_r == 8'h00)
   else $error("read data outside its cycle");
chk_unmapped_read: assert property (
   reg_rd && !(reg_addr inside {8'h36, 8'h38, 8'h39, 8'h3a}) |=> reg_rdata_r == 8'h00)
   else $error("unmapped read not zero");
chk_state_step: assert property (
   state_num_r != $past(state_num_r) |-> state_num_r == $past(state_num_r) + 2'd1)
   else $error("state skipped");
chk_cycle_wrap: assert property (cycle_end_r |-> state_num_r == 2'd0)
   else $error("cycle end away from S0");
chk_accept_enabled: assert property (irq_accept_r |-> $past(irq_master_enable) && !resume_next_r)
   else $error("accept without master enable");
chk_resume_disabled: assert property (resume_next_r |-> !$past(irq_master_enable))
   else $error("resume with master enable");
chk_release_run: assert property ($rose(irq_accept_r) || $rose(resume_next_r) |-> ##[0:2] cpu_run_r)
   else $error("cpu not restarted");
chk_idle_entry: assert property (
   reg_wr && reg_addr == 8'h39 && reg_wdata[4] && !reg_wdata[2]
   && cpu_run_r && !irq_req ##1 !irq_req
   |-> ##[1:2] (!cpu_run_r && !wdt_run_r && periph_run_r))
   else $error("idle entry wrong");
chk_latch_hold: assert property (
   base_timer_interrupt_r && !base_timer_irq_clear |=> base_timer_interrupt_r)
   else $error("timer latch lost");
chk_service_enables: assert property (
   base_timer_service_r |-> $past(irq_master_enable) && $past(base_timer_irq_enable))
   else $error("service without enables");
chk_dual_pins: assert property (low_osc_run_r |-> ##[0:2] !low_pins_port_r)
   else $error("low pins still ports");
cover property (irq_accept_r);
cover property (resume_next_r);
cover property (base_timer_service_r);
endmodule // sys_clock_ctrl_checker
bind sys_clock_ctrl sys_clock_ctrl_checker chk_i (.clk_sys(clk_sys), .arst_n(arst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata_r(reg_rdata_r), .irq_req(irq_req), .irq_master_enable(irq_master_enable),
   .base_timer_irq_enable(base_timer_irq_enable), .base_timer_irq_clear(base_timer_irq_clear),
   .state_num_r(state_num_r), .cycle_end_r(cycle_end_r), .cpu_run_r(cpu_run_r),
   .wdt_run_r(wdt_run_r), .periph_run_r(periph_run_r), .low_osc_run_r(low_osc_run_r),
   .low_pins_port_r(low_pins_port_r), .irq_accept_r(irq_accept_r),
   .resume_next_r(resume_next_r), .base_timer_service_r(base_timer_service_r),
   .base_timer_interrupt_r(base_timer_interrupt_r));
`default_nettype wire

// file: sys_clock_ctrl_consts.vh
// Purpose: Constants for the system clock and operating-mode controller
// Assumes: Byte-wide register port, one system clock
// Notes:   Offsets are byte addresses on the register port
`ifndef SYS_CLOCK_CTRL_CONSTS_VH
`define SYS_CLOCK_CTRL_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_TIMING_GEN_CONTROL 8'h36
`define OFS_SYSTEM_CONTROL_ONE 8'h38
`define OFS_SYSTEM_CONTROL_TWO 8'h39
`define OFS_MODE_STATUS 8'h3a

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_TIMING_GEN_CONTROL 8'h00
`define RST_SYSTEM_CONTROL_ONE 8'h00
`define RST_SYSTEM_CONTROL_TWO 8'h80

// ----------------------------------------------------------------
// timing_gen_control fields
// ----------------------------------------------------------------
`define TGC_DIVOUT_EN 7
`define TGC_DIVOUT_SEL_HI 6
`define TGC_DIVOUT_SEL_LO 5
`define TGC_DV7_SRC 4
`define TGC_TBT_EN 3
`define TGC_TBT_SEL_HI 2
`define TGC_TBT_SEL_LO 0

// ----------------------------------------------------------------
// system_control_one fields
// ----------------------------------------------------------------
`define SC1_STOP 7
`define SC1_REL_LEVEL 6
`define SC1_RET_SLOW 5
`define SC1_OUT_EN 4
`define SC1_WARM_HI 3
`define SC1_WARM_LO 2

// ----------------------------------------------------------------
// system_control_two fields
// ----------------------------------------------------------------
`define SC2_HIGH_OSC_EN 7
`define SC2_LOW_OSC_EN 6
`define SC2_SYS_CLK_SEL 5
`define SC2_IDLE 4
`define SC2_TG_HALT 2

// ----------------------------------------------------------------
// Structure and tap positions
// ----------------------------------------------------------------
`define PRESCALE_BITS 2
`define DIVIDER_BITS 21
`define STATES_PER_CYCLE 4
`define TBT_TAP_BASE 5'd13
`define WARM_TAP_BASE 5'd17
`define DIVOUT_TAP_BASE 5'd8

`endif

// file: sys_clock_ctrl_tb.sv
// Purpose: Self-checking bench of the system clock controller
// Assumes: High tick every cycle so deep idle ends inside the run
// Notes:   Low tick every 8 cycles gives a fixed slow machine cycle
`timescale 1ns/1ps
`default_nettype none
`include "sys_clock_ctrl_consts.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module testbench;
// ----------------------------------------------------------------
// Stimulus and design
// ----------------------------------------------------------------
logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, lf_tick = 1'b0;
logic irq_req = 1'b0, irq_master_enable = 1'b0, base_timer_irq_enable = 1'b0;
logic base_timer_irq_clear = 1'b0, sv, stop_release_n = 1'b1;
logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, v, r;
logic [3:0] inst_cycles = 4'h1;
logic [2:0] lf_cnt = 3'h0;
logic [20:0] div_taps_r;
logic [7:0] reg_rdata_r;
logic [1:0] state_num_r;
logic main_tick_r, cycle_end_r, inst_done_r, cpu_run_r, wdt_run_r, periph_run_r;
logic high_osc_run_r, low_osc_run_r, low_pins_port_r, divider_output_r, irq_accept_r;
logic resume_next_r, base_timer_service_r, base_timer_interrupt_r;
integer miscompares = 0, n_tests = 0, seed = 28743, i, j, k, c, m;
logic [7:0] addrs [0:3] = '{8'h36, 8'h38, 8'h39, 8'h50};
sys_clock_ctrl DUT (.clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
   .hf_tick(1'b1), .lf_tick(lf_tick), .irq_req(irq_req), .irq_master_enable(irq_master_enable),
   .base_timer_irq_enable(base_timer_irq_enable), .base_timer_irq_clear(base_timer_irq_clear),
   .stop_release_n(stop_release_n), .inst_cycles(inst_cycles), .div_taps_r(div_taps_r),
   .main_tick_r(main_tick_r), .state_num_r(state_num_r), .cycle_end_r(cycle_end_r),
   .inst_done_r(inst_done_r), .cpu_run_r(cpu_run_r), .wdt_run_r(wdt_run_r),
   .periph_run_r(periph_run_r), .high_osc_run_r(high_osc_run_r), .low_osc_run_r(low_osc_run_r),
   .low_pins_port_r(low_pins_port_r), .divider_output_r(divider_output_r),
   .irq_accept_r(irq_accept_r), .resume_next_r(resume_next_r),
   .base_timer_service_r(base_timer_service_r), .base_timer_interrupt_r(base_timer_interrupt_r));
initial begin
   forever #50 clk_sys = ~clk_sys;
end
always @(posedge clk_sys) begin
   lf_cnt <= lf_cnt + 3'h1;
   lf_tick <= (lf_cnt == 3'h7);
   // Held per instruction; 0 and 11..15 probe the clamp
   if (inst_done_r === 1'b1) begin
      inst_cycles <= 4'($unsigned($random(seed)));
   end
end
// ----------------------------------------------------------------
// Tasks and expectations
// ----------------------------------------------------------------
function [7:0] exp_rst(input [7:0] a);
   exp_rst = (a == `OFS_SYSTEM_CONTROL_TWO) ? `RST_SYSTEM_CONTROL_TWO : 8'h00;
endfunction
function integer exp_len(input [3:0] n);
   exp_len = (n == 4'h0) ? 1 : ((n > 4'ha) ? 10 : n);
endfunction
// Machine cycles of the next instruction, left in m
task instr;
   for (k = 0; k < 300 && inst_done_r !== 1'b1; k++) @(negedge clk_sys);
   tmo(k, 300);
   @(negedge clk_sys);
   m = 0;
   for (k = 0; k < 300 && inst_done_r !== 1'b1; k++) begin
      m += cycle_end_r;
      @(negedge clk_sys);
   end
   tmo(k, 300);
   m += cycle_end_r;
endtask
task wait_dvo(input logic b);
   for (k = 0; k < 3000 && divider_output_r !== b; k++) @(negedge clk_sys);
   tmo(k, 3000);
endtask
task final_report;
   $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
   if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
   else
      $display("Some tests failed");
   $finish;
endtask
task tmo(input integer n, input integer lim);
   if (n >= lim) begin
      miscompares++;
      $display("[ERR] %0t wait ran out", $time);
      final_report;
   end
endtask
task wr(input [7:0] a, input [7:0] d);
   @(posedge clk_sys);
   reg_wr <= 1'b1;
   reg_addr <= a;
   reg_wdata <= d;
   @(posedge clk_sys);
   reg_wr <= 1'b0;
endtask
task rd(input [7:0] a, output [7:0] d);
   @(posedge clk_sys);
   reg_rd <= 1'b1;
   reg_addr <= a;
   @(posedge clk_sys);
   reg_rd <= 1'b0;
   @(negedge clk_sys);
   d = reg_rdata_r;
endtask
// Period in clocks and main ticks of one machine cycle
task span;
   for (k = 0; k < 300 && cycle_end_r !== 1'b1; k++) @(negedge clk_sys);
   tmo(k, 300);
   c = 1;
   m = main_tick_r;
   @(negedge clk_sys);
   for (k = 0; k < 300 && cycle_end_r !== 1'b1; k++) begin
      c++;
      m += main_tick_r;
      @(negedge clk_sys);
   end
   tmo(k, 300);
endtask
// ----------------------------------------------------------------
// Main sequence
// ----------------------------------------------------------------
initial begin
   repeat (20) @(posedge clk_sys);
   `CHK({cpu_run_r, high_osc_run_r, low_osc_run_r, low_pins_port_r}, 4'b1101)
   `CHK(div_taps_r, 21'h000000)
   arst_n <= 1'b1;
   for (i = 0; i < 4; i++) begin
      rd(addrs[i], r);
      `CHK(r, exp_rst(addrs[i]))
   end
   // Stage-7 source kept clear: single clock must not select the low clock
   for (i = 0; i < 4; i++) begin
      v = $random(seed) & 8'hef;
      wr(`OFS_TIMING_GEN_CONTROL, v);
      rd(`OFS_TIMING_GEN_CONTROL, r);
      `CHK(r, v)
      wr(8'h50, v);
      rd(8'h50, r);
      `CHK(r, 8'h00)
   end
   wr(`OFS_TIMING_GEN_CONTROL, 8'h88);
   $display("test registers done");
   `CHK(div_taps_r != 21'h000000, 1'b1)
   span;
   `CHK(c, 4)
   `CHK(m, 4)
   $display("test machine cycle done");
   for (i = 0; i < 20; i++) begin
      instr;
      `CHK(m, exp_len(inst_cycles))
   end
   $display("test instruction length done");
   wait_dvo(1'b0);
   wait_dvo(1'b1);
   for (c = 0; c < 3000 && divider_output_r === 1'b1; c++) @(negedge clk_sys);
   `CHK(c, 1 << (`PRESCALE_BITS + `DIVOUT_TAP_BASE))
   $display("test divider output done");
   for (j = 0; j < 2; j++) begin
      irq_master_enable <= j[0];
      wr(`OFS_SYSTEM_CONTROL_TWO, 8'h90);
      repeat (3) @(negedge clk_sys);
      `CHK({cpu_run_r, wdt_run_r, periph_run_r}, 3'b001)
      @(posedge clk_sys);
      irq_req <= 1'b1;
      for (k = 0; k < 10 && !(irq_accept_r || resume_next_r); k++) @(negedge clk_sys);
      tmo(k, 10);
      `CHK({irq_accept_r, resume_next_r}, {j[0], !j[0]})
      @(posedge clk_sys);
      irq_req <= 1'b0;
      repeat (2) @(negedge clk_sys);
      `CHK(cpu_run_r, 1'b1)
      rd(`OFS_SYSTEM_CONTROL_TWO, r);
      `CHK(r, 8'h80)
   end
   $display("test idle done");
   base_timer_irq_enable <= 1'b1;
   irq_master_enable <= 1'b1;
   wr(`OFS_SYSTEM_CONTROL_TWO, 8'h84);
   repeat (3) @(negedge clk_sys);
   `CHK({cpu_run_r, periph_run_r}, 2'b00)
   sv = 1'b0;
   for (k = 0; k < 70000 && cpu_run_r !== 1'b1; k++) begin
      sv = sv | base_timer_service_r;
      @(negedge clk_sys);
   end
   tmo(k, 70000);
   repeat (2) begin
      sv = sv | base_timer_service_r;
      @(negedge clk_sys);
   end
   `CHK(sv, 1'b1)
   `CHK(periph_run_r, 1'b1)
   `CHK(base_timer_interrupt_r, 1'b1)
   rd(`OFS_MODE_STATUS, r);
   `CHK(r[4], 1'b1)
   @(posedge clk_sys);
   base_timer_irq_clear <= 1'b1;
   @(posedge clk_sys);
   base_timer_irq_clear <= 1'b0;
   @(negedge clk_sys);
   `CHK(base_timer_interrupt_r, 1'b0)
   $display("test deep idle done");
   wr(`OFS_SYSTEM_CONTROL_TWO, 8'hc0);
   repeat (3) @(negedge clk_sys);
   `CHK({low_osc_run_r, low_pins_port_r}, 2'b10)
   wr(`OFS_SYSTEM_CONTROL_TWO, 8'he0);
   span;
   span;
   `CHK(c, 32)
   `CHK(m, 4)
   wr(`OFS_SYSTEM_CONTROL_TWO, 8'h60);
   repeat (3) @(negedge clk_sys);
   `CHK({high_osc_run_r, cpu_run_r}, 2'b01)
   $display("test dual clock done");
   // Stop from slow, level release, return to slow
   wr(`OFS_SYSTEM_CONTROL_ONE, 8'he0);
   repeat (3) @(negedge clk_sys);
   `CHK({cpu_run_r, low_osc_run_r}, 2'b00)
   `CHK(div_taps_r == 21'h000000, 1'b1)
   @(posedge clk_sys);
   stop_release_n <= 1'b0;
   for (k = 0; k < 20000 && cpu_run_r !== 1'b1; k++) @(negedge clk_sys);
   tmo(k, 20000);
   @(posedge clk_sys);
   stop_release_n <= 1'b1;
   rd(`OFS_SYSTEM_CONTROL_ONE, r);
   `CHK(r, 8'h60)
   rd(`OFS_SYSTEM_CONTROL_TWO, r);
   `CHK(r, 8'h60)
   $display("test stop done");
   final_report;
end
endmodule // testbench
`default_nettype wire
